// ---- sem_pkg.sv ----
// Notes on behaviour
// R1: eight semaphore flags apart from memory array
// R2: semaphore select low, then normal SRAM controls
// R3: flag chosen by three lowest address bits
// R4: only data bit zero is written
// R5: write zero requests, write one releases
// R6: winner reads zero, other side reads one
// R7: holder release frees flag unless request pends
// R8: loser request waits, reads one until granted
// R9: flag value spread over all data bits
// R10: read value latched while select and enable low
// R11: drop select or enable between polling reads
// R12: write zero first, then read back
// R13: after failure, poll again or withdraw
// R14: one side only gets a contested flag
// R15: flags gate nothing, no wait states
// R16: port idle when enable and select high
// R17: software writes one to all flags at start
// R18: simultaneous tie resolved by fixed choice
package sem_pkg;
  // ---------------------------------------------------------------
  // pin widths and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int IDX_W = 3;
  localparam int FLAG_COUNT = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_NS = 200;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // command codes from the user side
  localparam logic [1:0] OP_CLAIM = 2'h0;
  localparam logic [1:0] OP_POLL = 2'h1;
  localparam logic [1:0] OP_RELEASE = 2'h2;
  localparam logic [1:0] OP_INIT = 2'h3;

  // pin group driven toward the device
  typedef struct packed {
    logic ce_n;
    logic semaphore_select_n;
    logic rw_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_en;
  } pins_type;

  // user request
  typedef struct packed {
    logic [1:0] op;
    logic [IDX_W-1:0] flag_index_bits;
  } cmd_type;
endpackage

// ---- sem_cycle.sv ----
`timescale 1ns/100ps
// one timed access on the semaphore space of the device
module sem_cycle
  import sem_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic write,
  input wire logic [IDX_W-1:0] idx,
  input wire logic wbit,
  input wire logic [DATA_W-1:0] din_sync,
  output logic done,
  output logic rbit,
  output pins_type pins
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_ACT = 3'b010,
    C_GAP = 3'b100
  } cyc_type;

  cyc_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic write_reg, rbit_reg, rbit_next;
  logic [IDX_W-1:0] idx_reg;
  logic wbit_reg;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  wire cnt_done = (cnt_reg == CNT_ZERO);
  // flag read is all ones or all zeros; bit zero is enough
  wire din_bit = din_sync[0]; // R9

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rbit_next = rbit_reg;
    case (state_reg)
      C_IDLE: begin
        if (start) begin
          state_next = C_ACT;
          cnt_next = CNT_W'(ACCESS_CYC);
        end
      end
      C_ACT: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_done) begin
          state_next = C_GAP;
          if (!write_reg) rbit_next = din_bit; // R10
        end
      end
      C_GAP: state_next = C_IDLE;
      default: state_next = C_IDLE;
    endcase
  end

  // pins idle high in C_IDLE and C_GAP: select and enable drop
  // between accesses so the output latch reloads next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= C_IDLE;
      cnt_reg <= CNT_ZERO;
      rbit_reg <= 1'b1;
      write_reg <= 1'b0;
      idx_reg <= '0;
      wbit_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rbit_reg <= rbit_next;
      if (start && state_reg == C_IDLE) begin
        write_reg <= write;
        idx_reg <= idx;
        wbit_reg <= wbit;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // pins launch with the move into C_ACT, not a cycle later, so the
  // read data has crossed both sync flops before the last active cycle
  wire load = start && (state_reg == C_IDLE);
  wire act = (state_next == C_ACT);
  wire write_cur = load ? write : write_reg;
  wire wbit_cur = load ? wbit : wbit_reg;
  wire [IDX_W-1:0] idx_cur = load ? idx : idx_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins <= '{ce_n: 1'b1, semaphore_select_n: 1'b1, rw_n: 1'b1,
                oe_n: 1'b1, addr: '0, dout: '0, dout_en: 1'b0};
    end else begin
      pins.ce_n <= 1'b1; // R16
      pins.semaphore_select_n <= !act; // R2
      pins.rw_n <= !(act && write_cur);
      pins.oe_n <= !(act && !write_cur); // R11
      pins.addr <= {{(ADDR_W-IDX_W){1'b0}}, idx_cur}; // R3
      pins.dout <= {{(DATA_W-1){1'b0}}, wbit_cur}; // R4
      pins.dout_en <= act && write_cur;
    end
  end

  assign done = (state_reg == C_GAP);
  assign rbit = rbit_reg;
endmodule

// ---- sem_host.sv ----
`timescale 1ns/100ps
// host controller claiming and releasing device semaphores
module sem_host
  import sem_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire cmd_type CMD,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic RESP_GRANTED,
  output logic [IDX_W-1:0] RESP_INDEX,
  output logic CE_N,
  output logic SEMAPHORE_SELECT_N,
  output logic RW_N,
  output logic OE_N,
  output logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_WR = 6'b000010,
    S_WR_W = 6'b000100,
    S_RD = 6'b001000,
    S_RD_W = 6'b010000,
    S_RESP = 6'b100000
  } st_type;

  st_type state_reg, state_next;
  logic [1:0] op_reg;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic granted_reg, granted_next;
  logic [DATA_W-1:0] din_meta_reg, din_sync_reg;
  logic cyc_done, cyc_rbit, cyc_start, cyc_write, cyc_wbit;
  pins_type pins;

  // ---------------------------------------------------------------
  // data pins pass two flops before use
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= DATA_IN;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // command sequencing
  // ---------------------------------------------------------------
  // claim writes zero then reads back; never read-then-write
  wire is_claim = (op_reg == OP_CLAIM); // R12
  wire is_poll = (op_reg == OP_POLL); // R13
  wire is_init = (op_reg == OP_INIT); // R17
  wire idx_last = (idx_reg == IDX_LAST);

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    granted_next = granted_reg;
    case (state_reg)
      S_IDLE: if (CMD_VALID) state_next = (CMD.op == OP_POLL) ? S_RD : S_WR;
      S_WR: state_next = S_WR_W;
      S_WR_W: begin
        if (cyc_done) begin
          if (is_claim) begin
            state_next = S_RD; // R12
          end else if (is_init && !idx_last) begin
            idx_next = idx_reg + 3'h1; // R1
            state_next = S_WR;
          end else begin
            state_next = S_RESP;
          end
        end
      end
      S_RD: state_next = S_RD_W;
      S_RD_W: begin
        if (cyc_done) begin
          granted_next = !cyc_rbit; // R6 R8
          state_next = S_RESP;
        end
      end
      S_RESP: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // tie between two hosts is settled inside the device; host
  // only trusts the read back value
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= S_IDLE;
      op_reg <= OP_POLL;
      idx_reg <= '0;
      granted_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      granted_reg <= granted_next; // R14 R18
      if (state_reg == S_IDLE && CMD_VALID) begin
        op_reg <= CMD.op;
        idx_reg <= (CMD.op == OP_INIT) ? '0 : CMD.flag_index_bits;
        granted_reg <= 1'b0;
      end else begin
        idx_reg <= idx_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // access engine; releases and init write one, claims write zero
  // ---------------------------------------------------------------
  assign cyc_start = (state_reg == S_WR) || (state_reg == S_RD);
  assign cyc_write = (state_reg == S_WR);
  assign cyc_wbit = !is_claim; // R5 R7

  sem_cycle u_cycle (
    .clk(CLK),
    .nrst(NRST),
    .start(cyc_start),
    .write(cyc_write),
    .idx(idx_reg),
    .wbit(cyc_wbit),
    .din_sync(din_sync_reg),
    .done(cyc_done),
    .rbit(cyc_rbit),
    .pins(pins)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // no wait states: nothing here waits on the device
  assign CMD_READY = (state_reg == S_IDLE); // R15
  assign RESP_VALID = (state_reg == S_RESP);
  assign RESP_GRANTED = granted_reg && !is_init && (is_claim || is_poll);
  assign RESP_INDEX = idx_reg;
  assign CE_N = pins.ce_n;
  assign SEMAPHORE_SELECT_N = pins.semaphore_select_n;
  assign RW_N = pins.rw_n;
  assign OE_N = pins.oe_n;
  assign ADDR = pins.addr;
  assign DATA_OUT = pins.dout;
  assign DATA_OE = pins.dout_en;
endmodule

// ---- sem_host_properties.sv ----
`timescale 1ns/100ps
// pin-level checks on the host side of the flag port
module sem_host_properties
  import sem_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire cmd_type CMD,
  input wire logic CMD_READY,
  input wire logic RESP_VALID,
  input wire logic SEMAPHORE_SELECT_N,
  input wire logic RW_N,
  input wire logic OE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic DATA_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // accepted command, decoded once
  wire take = CMD_VALID && CMD_READY;
  sequence wr_acc(b);
    !SEMAPHORE_SELECT_N && !RW_N && DATA_OE && DATA_OUT[0] == b;
  endsequence
  sequence held_low;
    !SEMAPHORE_SELECT_N [*3] ##1 SEMAPHORE_SELECT_N;
  endsequence
  chk_addr_upper:
  assert property (!SEMAPHORE_SELECT_N |-> ADDR[15:3] == 13'h0)
    else $error("upper address bits set");
  chk_data_upper:
  assert property (DATA_OE |-> DATA_OUT[15:1] == 15'h0)
    else $error("upper data bits set");
  chk_select_gap:
  assert property ($fell(SEMAPHORE_SELECT_N) |-> held_low)
    else $error("select not three cycles then high");
  chk_rw_oe_apart:
  assert property (!RW_N |-> OE_N && DATA_OE)
    else $error("write with output enable");
  chk_claim_zero:
  assert property (take && CMD.op == OP_CLAIM |-> ##[1:3] wr_acc(1'b0))
    else $error("claim did not write zero");
  chk_release_one:
  assert property (take && CMD.op == OP_RELEASE |-> ##[1:3] wr_acc(1'b1))
    else $error("release did not write one");
  chk_poll_read:
  assert property (take && CMD.op == OP_POLL |->
    ##[1:3] (!SEMAPHORE_SELECT_N && !OE_N && RW_N))
    else $error("poll did not read");
  chk_resp_pulse:
  assert property (RESP_VALID |=> !RESP_VALID && CMD_READY)
    else $error("response not one cycle");
endmodule
bind sem_host sem_host_properties props(.CLK(CLK), .NRST(NRST),
  .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
  .RESP_VALID(RESP_VALID), .SEMAPHORE_SELECT_N(SEMAPHORE_SELECT_N),
  .RW_N(RW_N), .OE_N(OE_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE));

// ---- sem_dev.sv ----
`timescale 1ns/100ps
// flag device, host is side 0
module sem_dev
  import sem_pkg::*;
(
  input wire logic CLK,
  input wire logic SEMAPHORE_SELECT_N,
  input wire logic RW_N,
  input wire logic OE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic DATA_OE,
  output logic [DATA_W-1:0] DATA_IN
);
  // holder: 0 free, 1 host, 2 far; power-up junk on purpose
  logic [1:0] hold [FLAG_COUNT] = '{default: 2'h1};
  logic pend [2][FLAG_COUNT] = '{default: '{default: 1'b0}};
  logic [DATA_W-1:0] rd_reg = 16'h0;
  logic wr_seen = 1'b0;
  logic rd_seen = 1'b0;
  // callers run in turn, so a tie goes to the first caller
  task automatic put(input int s, input int i, input logic b);
    logic [1:0] me;
    me = 2'(s + 1);
    if (!b) begin
      if (hold[i] == 2'h0) hold[i] = me;
      else if (hold[i] != me) pend[s][i] = 1'b1;
    end else begin
      pend[s][i] = 1'b0;
      if (hold[i] == me) hold[i] = pend[1-s][i] ? 2'(2 - s) : 2'h0;
      if (hold[i] == 2'(2 - s)) pend[1-s][i] = 1'b0;
    end
  endtask
  // pins sampled mid-cycle, away from the host's launch edge
  always @(negedge CLK) begin
    if (SEMAPHORE_SELECT_N) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
    end else if (!RW_N && DATA_OE && !wr_seen) begin
      put(0, int'(ADDR[2:0]), DATA_OUT[0]);
      wr_seen <= 1'b1;
    end else if (!OE_N && !rd_seen) begin
      rd_reg <= {DATA_W{hold[ADDR[2:0]] != 2'h1}};
      rd_seen <= 1'b1;
    end
  end
  // idle bus shows the inverse, never the held value
  assign DATA_IN = rd_seen ? rd_reg : ~rd_reg;
endmodule

// ---- sem_host_test.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module sem_host_test
  import sem_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd = 5'h0;
  logic cmd_ready, resp_valid, resp_granted, sel_n, rw_n, oe_n, data_oe;
  logic ce_n;
  logic [IDX_W-1:0] resp_index;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out;
  int bad_count = 0;
  int checked = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  sem_host dut(.CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD(cmd),
    .CMD_READY(cmd_ready), .RESP_VALID(resp_valid),
    .RESP_GRANTED(resp_granted), .RESP_INDEX(resp_index), .CE_N(ce_n),
    .SEMAPHORE_SELECT_N(sel_n), .RW_N(rw_n), .OE_N(oe_n), .ADDR(addr),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe));
  sem_dev dev(.CLK(clk), .SEMAPHORE_SELECT_N(sel_n), .RW_N(rw_n),
    .OE_N(oe_n), .ADDR(addr), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .DATA_IN(data_in));
  task automatic results();
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one command; bounded wait, answer judged mid-cycle
  task automatic run(input logic [1:0] op, input int i, input logic g);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, flag_index_bits: 3'(i)};
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 300);
    if (n >= 300) begin
      bad_count++;
      results();
    end
    `CHK("granted", g, resp_granted)
    `CHK("index", (op == OP_INIT) ? IDX_LAST : 3'(i), resp_index)
    `CHK("ce_n", 1'b1, ce_n)
  endtask
  // flags hold junk until the host frees them all
  task automatic s_init();
    run(OP_INIT, 0, 1'b0);
    for (int i = 0; i < FLAG_COUNT; i++) begin
      `CHK("free", 2'h0, dev.hold[i])
    end
  endtask
  // every index claimed and let go
  task automatic s_each();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      run(OP_CLAIM, i, 1'b1);
      `CHK("held", 2'h1, dev.hold[i])
      run(OP_RELEASE, i, 1'b0);
    end
  endtask
  // far side queues behind the host, then the host behind it
  task automatic s_contest();
    run(OP_CLAIM, 5, 1'b1);
    dev.put(1, 5, 1'b0);
    run(OP_POLL, 5, 1'b1);
    run(OP_RELEASE, 5, 1'b0);
    `CHK("far won", 2'h2, dev.hold[5])
    run(OP_CLAIM, 5, 1'b0);
    run(OP_POLL, 5, 1'b0);
    run(OP_RELEASE, 5, 1'b0);
    `CHK("withdrawn", 1'b0, dev.pend[0][5])
    `CHK("still far", 2'h2, dev.hold[5])
    run(OP_CLAIM, 5, 1'b0);
    dev.put(1, 5, 1'b1);
    run(OP_POLL, 5, 1'b1);
    run(OP_RELEASE, 5, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    s_init();
    s_each();
    s_contest();
    results();
  end
endmodule
